//--- hdl/cmis_regs.svh
// Offsets, field positions, reset values and timing counts of the mode and input select block.
// Assumes a 100 MHz system clock and one aligned 32-bit word per register.
`ifndef CMIS_REGS_SVH
`define CMIS_REGS_SVH

`define CMIS_CLK_MHZ 100
`define CMIS_SCAN_PERIOD_US 5000
`define CMIS_NUM_STROBES 8
`define CMIS_SCAN_DWELL_CYC (`CMIS_SCAN_PERIOD_US * `CMIS_CLK_MHZ / `CMIS_NUM_STROBES)
`define CMIS_GATE_MS_0 10
`define CMIS_GATE_MS_1 100
`define CMIS_GATE_MS_2 1000
`define CMIS_GATE_MS_3 10000
`define CMIS_GATE_SCANS(ms) ((ms) * 1000 / `CMIS_SCAN_PERIOD_US)
`define CMIS_REF_HALF_CYC 5
`define CMIS_DIV_CH1 10
`define CMIS_DIV_CH2 256

`define CMIS_ADDR_CTRL 8'h00
`define CMIS_ADDR_STATUS 8'h04
`define CMIS_ADDR_READING 8'h08
`define CMIS_ADDR_LIVE 8'h0C

`define CMIS_CTRL_FUNCTION_SELECT_LSB 0
`define CMIS_CTRL_GATE_LSB 4
`define CMIS_CTRL_HOLD_BIT 8
`define CMIS_CTRL_CLEAR_BIT 9
`define CMIS_CTRL_FUNCTION_SELECT_RST 3'h0
`define CMIS_CTRL_GATE_RST 2'h2

`define CMIS_ST_INHIBIT_BIT 8
`define CMIS_ST_CHSEL_BIT 9
`define CMIS_ST_DECODE_BIT 10
`define CMIS_ST_MEAS_N_BIT 11
`define CMIS_ST_CNTIN_BIT 12

`define CMIS_RESP_OKAY 2'h0
`define CMIS_RESP_SLVERR 2'h2

`endif

//--- hdl/cmis_pkg.sv
// Types shared by the mode and input select block.
// Assumes cmis_regs.svh for all numeric constants.
package cmis_pkg;
	typedef enum logic [2:0] {FN_KHZ, FN_MHZ, FN_CH2, FN_PERIOD, FN_TOTAL, FN_CHECK} cmis_function_select_t;
	typedef enum logic [1:0] {GATE_10MS, GATE_100MS, GATE_1S, GATE_10S} cmis_gate_t;
	typedef enum {MEAS_IDLE, MEAS_OPEN, MEAS_TOTAL} cmis_meas_t;
endpackage : cmis_pkg

//--- hdl/cmis_div_if.sv
// Carrier between the top block and an edge-counting divider.
// Assumes the source drives one-cycle tick pulses on MCLK.
`timescale 1ns/1ps
interface cmis_div_if;
	logic tick;
	logic clear;
	logic square;
	modport src (output tick, output clear, input square);
	modport div (input tick, input clear, output square);
endinterface : cmis_div_if

//--- hdl/cmis_divider.sv
// Edge-counting divider: square output at 1/DIV of the tick rate.
// Assumes ticks are one-cycle pulses synchronous to MCLK.
`timescale 1ns/1ps
module cmis_divider #(
	parameter int DIV = 10
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	cmis_div_if.div port_if
);
	localparam int HALF = DIV / 2;
	localparam int W = $clog2(HALF + 1);

	logic [W-1:0] edge_cnt_reg;
	logic square_reg;

	// Refuse odd or tiny ratios while the design is being built
	if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
		$error("cmis_divider: DIV must be even and at least 2");
	end

	// Toggle every DIV/2 input edges gives one output cycle per DIV inputs
	always_ff @(posedge MCLK) begin
		if (SYS_RST || port_if.clear) begin
			edge_cnt_reg <= '0;
			square_reg <= 1'b0;
		end else if (port_if.tick) begin
			if (edge_cnt_reg == W'(HALF - 1)) begin
				edge_cnt_reg <= '0;
				square_reg <= ~square_reg;
			end else begin
				edge_cnt_reg <= edge_cnt_reg + 1'b1;
			end
		end
	end

	assign port_if.square = square_reg;
endmodule : cmis_divider

//--- hdl/cmis_top.sv
// Mode selection and counter input routing, with digit scan, gate timer and AXI4-Lite registers.
// Assumes CH1_IN, CH2_IN and EXT_INHIBIT_N are already synchronous to MCLK.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "cmis_regs.svh"
module cmis_top import cmis_pkg::*; #(
	parameter int DWELL_CYC = `CMIS_SCAN_DWELL_CYC,
	parameter int CNT_W = 32
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic CH1_IN,
	input wire logic CH2_IN,
	input wire logic EXT_INHIBIT_N,
	output logic [7:0] DIGIT_STROBE,
	output logic GATE_TIME_CTL,
	output logic DECIMAL_CTL,
	output logic FUNCTION_CTL,
	output logic CHANNEL_SELECT,
	output logic MODE_DECODE,
	output logic TOTAL_GATE,
	output logic INHIBIT,
	output logic DIRECT_GATE,
	output logic COUNTER_IN,
	output logic MEAS_ACTIVE_N,
	output logic GATE_IND_ON
);
	localparam int DW_W = $clog2(DWELL_CYC + 1);

	// Each strobe must dwell at least two cycles for the scan check
	if (DWELL_CYC < 2 || CNT_W < 13 || CNT_W > 32) begin : g_bad_param
		$error("cmis_top: DWELL_CYC must be >= 2 and CNT_W within 13..32");
	end

	cmis_function_select_t function_select_reg;
	cmis_gate_t gate_reg;
	logic hold_reg, clear_reg;
	logic aw_got_reg, w_got_reg, bvalid_reg, awready_reg, wready_reg, arready_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [DW_W-1:0] dwell_reg;
	logic [7:0] strobe_reg, strobe_out_reg;
	logic scan_end;
	logic gate_ctl_reg, dec_ctl_reg, function_select_ctl_reg, chsel_reg, decode_reg, total_reg;
	logic inhibit_reg, direct_reg, cnt_in_reg, cnt_prev_reg, meas_n_reg, gate_ind_reg;
	logic ch1_q_reg, ch2_q_reg, ref_reg;
	logic [2:0] ref_cnt_reg;
	logic src_sel, blocked;
	cmis_meas_t meas_reg;
	logic [11:0] scans_reg, scans_target;
	logic [CNT_W-1:0] live_reg, reading_reg;
	logic [31:0] status_word;

	cmis_div_if div10_if ();
	cmis_div_if pre256_if ();

	// AXI4-Lite write: address and data taken in either order, response after both
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `CMIS_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && awready_reg) begin
				aw_got_reg <= 1'b1;
				awready_reg <= 1'b0;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && wready_reg) begin
				w_got_reg <= 1'b1;
				wready_reg <= 1'b0;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (aw_got_reg && w_got_reg && !bvalid_reg) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= (aw_addr_reg == `CMIS_ADDR_CTRL) ? `CMIS_RESP_OKAY : `CMIS_RESP_SLVERR;
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
			end
			if (bvalid_reg && S_AXI_BREADY) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// Control register; illegal function codes keep the old selection
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			function_select_reg <= cmis_function_select_t'(`CMIS_CTRL_FUNCTION_SELECT_RST);
			gate_reg <= cmis_gate_t'(`CMIS_CTRL_GATE_RST);
			hold_reg <= 1'b0;
			clear_reg <= 1'b0;
		end else begin
			clear_reg <= 1'b0;
			if (aw_got_reg && w_got_reg && !bvalid_reg && aw_addr_reg == `CMIS_ADDR_CTRL) begin
				if (w_strb_reg[0]) begin
					if (w_data_reg[`CMIS_CTRL_FUNCTION_SELECT_LSB +: 3] <= 3'(FN_CHECK)) begin
						function_select_reg <= cmis_function_select_t'(w_data_reg[`CMIS_CTRL_FUNCTION_SELECT_LSB +: 3]);
					end
					gate_reg <= cmis_gate_t'(w_data_reg[`CMIS_CTRL_GATE_LSB +: 2]);
				end
				if (w_strb_reg[1]) begin
					hold_reg <= w_data_reg[`CMIS_CTRL_HOLD_BIT];
					clear_reg <= w_data_reg[`CMIS_CTRL_CLEAR_BIT];
				end
			end
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[7:0] = strobe_out_reg;
		status_word[`CMIS_ST_INHIBIT_BIT] = inhibit_reg;
		status_word[`CMIS_ST_CHSEL_BIT] = chsel_reg;
		status_word[`CMIS_ST_DECODE_BIT] = decode_reg;
		status_word[`CMIS_ST_MEAS_N_BIT] = meas_n_reg;
		status_word[`CMIS_ST_CNTIN_BIT] = cnt_in_reg;
	end

	// AXI4-Lite read: one cycle from address to data
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `CMIS_RESP_OKAY;
		end else if (S_AXI_ARVALID && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= `CMIS_RESP_OKAY;
			case (S_AXI_ARADDR)
				`CMIS_ADDR_CTRL: begin
					rdata_reg <= {22'h00_0000, 1'b0, hold_reg, 2'h0, gate_reg, 1'b0, function_select_reg};
				end
				`CMIS_ADDR_STATUS: begin
					rdata_reg <= status_word;
				end
				`CMIS_ADDR_READING: begin
					rdata_reg <= 32'(reading_reg);
				end
				`CMIS_ADDR_LIVE: begin
					rdata_reg <= 32'(live_reg);
				end
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= `CMIS_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && S_AXI_RREADY) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// Digit strobe scan, one strobe active at a time
	assign scan_end = strobe_reg[7] && dwell_reg == DW_W'(DWELL_CYC - 1);
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			dwell_reg <= '0;
			strobe_reg <= 8'h01;
		end else if (dwell_reg == DW_W'(DWELL_CYC - 1)) begin
			dwell_reg <= '0;
			strobe_reg <= {strobe_reg[6:0], strobe_reg[7]};
		end else begin
			dwell_reg <= dwell_reg + 1'b1;
		end
	end

	// Strobe feedback to the counter's gate, function and decimal controls
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			strobe_out_reg <= 8'h00;
			gate_ctl_reg <= 1'b0;
			dec_ctl_reg <= 1'b0;
			function_select_ctl_reg <= 1'b0;
		end else begin
			strobe_out_reg <= strobe_reg;
			gate_ctl_reg <= strobe_reg[gate_reg];
			case (function_select_reg)
				FN_MHZ: begin
					dec_ctl_reg <= strobe_reg[3'(gate_reg) + 3'd3];
				end
				FN_CH2: begin
					dec_ctl_reg <= strobe_reg[3'(gate_reg) + 3'd2];
				end
				default: begin
					dec_ctl_reg <= 1'b0;
				end
			endcase
			case (function_select_reg)
				FN_PERIOD: begin
					function_select_ctl_reg <= strobe_reg[7];
				end
				FN_TOTAL: begin
					function_select_ctl_reg <= strobe_reg[3];
				end
				FN_CHECK: begin
					function_select_ctl_reg <= strobe_reg[2];
				end
				default: begin
					function_select_ctl_reg <= strobe_reg[0];
				end
			endcase
		end
	end

	// Input edge capture and 10 MHz self-check reference
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			ch1_q_reg <= 1'b0;
			ch2_q_reg <= 1'b0;
			ref_cnt_reg <= 3'h0;
			ref_reg <= 1'b0;
		end else begin
			ch1_q_reg <= CH1_IN;
			ch2_q_reg <= CH2_IN;
			if (ref_cnt_reg == 3'(`CMIS_REF_HALF_CYC - 1)) begin
				ref_cnt_reg <= 3'h0;
				ref_reg <= ~ref_reg;
			end else begin
				ref_cnt_reg <= ref_cnt_reg + 1'b1;
			end
		end
	end

	assign div10_if.tick = CH1_IN && !ch1_q_reg;
	assign div10_if.clear = 1'b0;
	assign pre256_if.tick = CH2_IN && !ch2_q_reg;
	assign pre256_if.clear = 1'b0;

	cmis_divider #(.DIV(`CMIS_DIV_CH1)) u_decade_divider (
		.MCLK(MCLK),
		.SYS_RST(SYS_RST),
		.port_if(div10_if)
	);

	cmis_divider #(.DIV(`CMIS_DIV_CH2)) u_ch2_prescaler (
		.MCLK(MCLK),
		.SYS_RST(SYS_RST),
		.port_if(pre256_if)
	);

	// Source selection and totalize gating
	assign blocked = (function_select_reg == FN_TOTAL) && (hold_reg || !EXT_INHIBIT_N);
	always_comb begin
		case (function_select_reg)
			FN_CH2: begin
				src_sel = pre256_if.square;
			end
			FN_MHZ: begin
				src_sel = div10_if.square;
			end
			FN_CHECK: begin
				src_sel = ref_reg;
			end
			default: begin
				src_sel = CH1_IN;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			chsel_reg <= 1'b0;
			decode_reg <= 1'b0;
			total_reg <= 1'b0;
			inhibit_reg <= 1'b0;
			direct_reg <= 1'b0;
			cnt_in_reg <= 1'b0;
			cnt_prev_reg <= 1'b0;
		end else begin
			cnt_prev_reg <= cnt_in_reg;
			chsel_reg <= function_select_reg == FN_CH2;
			decode_reg <= function_select_reg == FN_MHZ || function_select_reg == FN_CH2;
			total_reg <= function_select_reg == FN_TOTAL;
			inhibit_reg <= blocked;
			direct_reg <= blocked ? 1'b1 : ~src_sel;
			cnt_in_reg <= blocked ? 1'b0 : src_sel;
		end
	end

	// Gate timer, reading counter and clear switch
	always_comb begin
		case (gate_reg)
			GATE_10MS: begin
				scans_target = 12'(`CMIS_GATE_SCANS(`CMIS_GATE_MS_0));
			end
			GATE_100MS: begin
				scans_target = 12'(`CMIS_GATE_SCANS(`CMIS_GATE_MS_1));
			end
			GATE_1S: begin
				scans_target = 12'(`CMIS_GATE_SCANS(`CMIS_GATE_MS_2));
			end
			default: begin
				scans_target = 12'(`CMIS_GATE_SCANS(`CMIS_GATE_MS_3));
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST || clear_reg) begin
			meas_reg <= MEAS_IDLE;
			scans_reg <= 12'h000;
			live_reg <= '0;
			reading_reg <= '0;
		end else begin
			// Count rising edges of the routed counter input
			if (cnt_in_reg && !cnt_prev_reg && meas_reg != MEAS_IDLE) begin
				live_reg <= live_reg + 1'b1;
			end
			case (meas_reg)
				MEAS_IDLE: begin
					scans_reg <= 12'h000;
					live_reg <= '0;
					meas_reg <= (function_select_reg == FN_TOTAL) ? MEAS_TOTAL : MEAS_OPEN;
				end
				MEAS_OPEN: begin
					if (function_select_reg == FN_TOTAL) begin
						meas_reg <= MEAS_IDLE;
					end else if (scan_end) begin
						if (scans_reg >= scans_target - 12'h001) begin
							reading_reg <= live_reg;
							meas_reg <= MEAS_IDLE;
						end else begin
							scans_reg <= scans_reg + 12'h001;
						end
					end
				end
				MEAS_TOTAL: begin
					reading_reg <= live_reg;
					if (function_select_reg != FN_TOTAL) begin
						meas_reg <= MEAS_IDLE;
					end
				end
				default: begin
					meas_reg <= MEAS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			meas_n_reg <= 1'b1;
			gate_ind_reg <= 1'b0;
		end else begin
			meas_n_reg <= !(meas_reg == MEAS_OPEN || (meas_reg == MEAS_TOTAL && !blocked));
			gate_ind_reg <= meas_reg == MEAS_OPEN || (meas_reg == MEAS_TOTAL && !blocked);
		end
	end

	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY = wready_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign DIGIT_STROBE = strobe_out_reg;
	assign GATE_TIME_CTL = gate_ctl_reg;
	assign DECIMAL_CTL = dec_ctl_reg;
	assign FUNCTION_CTL = function_select_ctl_reg;
	assign CHANNEL_SELECT = chsel_reg;
	assign MODE_DECODE = decode_reg;
	assign TOTAL_GATE = total_reg;
	assign INHIBIT = inhibit_reg;
	assign DIRECT_GATE = direct_reg;
	assign COUNTER_IN = cnt_in_reg;
	assign MEAS_ACTIVE_N = meas_n_reg;
	assign GATE_IND_ON = gate_ind_reg;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	property p_gate_route;
		!$past(SYS_RST) |-> GATE_TIME_CTL == DIGIT_STROBE[$past(gate_reg)];
	endproperty
	a_gate_route: assert property (p_gate_route) else $error("gate control strobe wrong");
	property p_mhz_dec;
		!$past(SYS_RST) && $past(function_select_reg) == FN_MHZ |-> DECIMAL_CTL == DIGIT_STROBE[3'($past(gate_reg)) + 3'd3];
	endproperty
	a_mhz_dec: assert property (p_mhz_dec) else $error("MHz decimal strobe wrong");
	property p_ch2_dec;
		!$past(SYS_RST) && $past(function_select_reg) == FN_CH2 |-> DECIMAL_CTL == DIGIT_STROBE[3'($past(gate_reg)) + 3'd2];
	endproperty
	a_ch2_dec: assert property (p_ch2_dec) else $error("channel-2 decimal strobe wrong");
	property p_function_select_total;
		!$past(SYS_RST) && $past(function_select_reg) == FN_TOTAL |-> FUNCTION_CTL == DIGIT_STROBE[3];
	endproperty
	a_function_select_total: assert property (p_function_select_total) else $error("totalize function strobe wrong");
	property p_scan;
		$rose(strobe_reg[1]) |-> strobe_reg == 8'h02 ##1 strobe_reg == 8'h02;
	endproperty
	a_scan: assert property (p_scan) else $error("strobe scan order wrong");
	property p_ch1_direct;
		!$past(SYS_RST) && $past(function_select_reg) == FN_KHZ |-> COUNTER_IN == $past(CH1_IN);
	endproperty
	a_ch1_direct: assert property (p_ch1_direct) else $error("counter input not channel one");
	property p_chsel;
		!$past(SYS_RST) |-> CHANNEL_SELECT == ($past(function_select_reg) == FN_CH2);
	endproperty
	a_chsel: assert property (p_chsel) else $error("channel select wrong");
	property p_inhibit;
		blocked |=> COUNTER_IN == 1'b0 && DIRECT_GATE == 1'b1 && INHIBIT;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibit did not block input");
	property p_total_gate;
		function_select_reg != FN_TOTAL |=> !TOTAL_GATE && !INHIBIT;
	endproperty
	a_total_gate: assert property (p_total_gate) else $error("totalize gating high outside totalize");
	property p_clear;
		clear_reg |=> reading_reg == '0 ##1 reading_reg == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("reset switch did not clear readings");
	property p_gate_led;
		GATE_IND_ON == !MEAS_ACTIVE_N;
	endproperty
	a_gate_led: assert property (p_gate_led) else $error("gate indicator disagrees with measurement");
	property p_one_function_select;
		function_select_reg <= FN_CHECK && $onehot(strobe_reg);
	endproperty
	a_one_function_select: assert property (p_one_function_select) else $error("illegal function or strobe state");
	property p_div10;
		$changed(div10_if.square) |-> $past(div10_if.tick);
	endproperty
	a_div10: assert property (p_div10) else $error("decade divider moved without input edge");
	property p_mhz_route;
		!$past(SYS_RST) && $past(function_select_reg) == FN_MHZ |-> COUNTER_IN == $past(div10_if.square);
	endproperty
	a_mhz_route: assert property (p_mhz_route) else $error("MHz path not divided");

	c_mhz: cover property (function_select_reg == FN_MHZ && scan_end);
	c_total_blocked: cover property (function_select_reg == FN_TOTAL && blocked ##1 !blocked);
	c_reading: cover property (meas_reg == MEAS_OPEN ##1 meas_reg == MEAS_IDLE);
endmodule : cmis_top

//--- test/cmis_panel_model.sv
// Front-panel and signal-source model: conditioned channel squares and the rear inhibit connector.
// Assumes the bench drives ext_low on MCLK edges; the connector idles high through its pull-up.
`timescale 1ns/1ps
module cmis_panel_model #(
	parameter int CH1_HALF = 2,
	parameter int CH2_HALF = 1
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic ext_low,
	output logic ch1_in,
	output logic ch2_in,
	output logic ext_inhibit_n
);
	int ch1_cnt;
	int ch2_cnt;
	// Free-running squares, changed just after the clock edge like a synchronised source
	always @(posedge MCLK) begin
		if (SYS_RST) begin
			ch1_cnt <= 0;
			ch2_cnt <= 0;
			ch1_in <= 1'b0;
			ch2_in <= 1'b0;
		end else begin
			ch1_cnt <= (ch1_cnt == CH1_HALF - 1) ? 0 : ch1_cnt + 1;
			ch2_cnt <= (ch2_cnt == CH2_HALF - 1) ? 0 : ch2_cnt + 1;
			if (ch1_cnt == CH1_HALF - 1) ch1_in <= ~ch1_in;
			if (ch2_cnt == CH2_HALF - 1) ch2_in <= ~ch2_in;
		end
	end
	// Pulled up unless a low is applied at the connector
	assign ext_inhibit_n = ~ext_low;
endmodule : cmis_panel_model

//--- test/testbench.sv
// Self-checking bench for the mode and input select block, driven over AXI4-Lite.
// Assumes the panel model gives a channel-1 period of 4 cycles and a channel-2 period of 2.
`timescale 1ns/1ps
`include "cmis_regs.svh"
module testbench;
	localparam int DW = 4;
	localparam int WIN = 5120;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ext_low = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, ch1_in, ch2_in, ext_inhibit_n;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [7:0] digit_strobe;
	logic gate_time_ctl, decimal_ctl, function_ctl, channel_select, mode_decode, total_gate;
	logic inhibit, direct_gate, counter_in, meas_active_n, gate_ind_on;
	int mismatches = 0, n_compared = 0, cycles = 0;
	int fn_tab[5] = '{0, 1, 2, 3, 5};
	int exp_tab[5] = '{WIN / 4, WIN / 40, WIN / 2 / 256, WIN / 4, WIN / 10};

	always #5 mclk = ~mclk;

	cmis_top #(.DWELL_CYC(DW)) DUT (
		.MCLK(mclk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CH1_IN(ch1_in), .CH2_IN(ch2_in),
		.EXT_INHIBIT_N(ext_inhibit_n), .DIGIT_STROBE(digit_strobe), .GATE_TIME_CTL(gate_time_ctl),
		.DECIMAL_CTL(decimal_ctl), .FUNCTION_CTL(function_ctl), .CHANNEL_SELECT(channel_select),
		.MODE_DECODE(mode_decode), .TOTAL_GATE(total_gate), .INHIBIT(inhibit), .DIRECT_GATE(direct_gate),
		.COUNTER_IN(counter_in), .MEAS_ACTIVE_N(meas_active_n), .GATE_IND_ON(gate_ind_on)
	);
	cmis_panel_model PANEL (.MCLK(mclk), .SYS_RST(sys_rst), .ext_low(ext_low), .ch1_in(ch1_in),
		.ch2_in(ch2_in), .ext_inhibit_n(ext_inhibit_n));

	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : axi_read

	task automatic set_ctrl(input int f, input int g, input int h, input int c);
		logic [1:0] r;
		axi_write(`CMIS_ADDR_CTRL, 32'((c << 9) | (h << 8) | (g << 4) | f), r);
		check(r, `CMIS_RESP_OKAY);
		repeat (2) @(posedge mclk);
	endtask : set_ctrl

	// Counts counter-input rising edges; optionally checks it trails channel one by a cycle
	task automatic watch(input int cyc, input bit follow, output int ce, output int lo);
		logic prev_ci;
		logic prev_ch1;
		ce = 0;
		lo = 0;
		@(posedge mclk);
		#1;
		prev_ci = counter_in;
		prev_ch1 = ch1_in;
		repeat (cyc) begin
			@(posedge mclk);
			#1;
			if (follow) check(counter_in, prev_ch1);
			check(gate_ind_on ^ meas_active_n, 1);
			if (counter_in === 1'b1 && prev_ci === 1'b0) ce++;
			if (meas_active_n === 1'b0) lo++;
			prev_ci = counter_in;
			prev_ch1 = ch1_in;
		end
	endtask : watch

	function automatic logic near(input int a, input int b);
		return (a - b <= 1) && (b - a <= 1);
	endfunction : near

	initial begin
		int f, g, k, fs, hi0, ce, lo;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		axi_read(`CMIS_ADDR_CTRL, rd, resp);
		check(rd, 32'h0000_0020);
		axi_read(8'h10, rd, resp);
		check(rd, 32'h0000_0000);
		check(resp, `CMIS_RESP_SLVERR);
		axi_write(8'h10, 32'h0000_0001, resp);
		check(resp, `CMIS_RESP_SLVERR);
		$display("Test register map done");
		for (f = 0; f < 6; f++) begin
			for (g = 0; g < 4; g++) begin
				set_ctrl(f, g, 0, 0);
				fs = (f == 3) ? 7 : (f == 4) ? 3 : (f == 5) ? 2 : 0;
				hi0 = 0;
				repeat (8 * DW) begin
					@(posedge mclk);
					#1;
					check($onehot(digit_strobe), 1);
					check(gate_time_ctl, digit_strobe[g]);
					check(function_ctl, digit_strobe[fs]);
					check(decimal_ctl, f == 1 ? digit_strobe[g + 3] : f == 2 ? digit_strobe[g + 2] : 1'b0);
					hi0 += digit_strobe[0];
				end
				check(hi0, DW);
				check(channel_select, f == 2);
				check(mode_decode, f == 1 || f == 2);
				check(total_gate, f == 4);
				axi_read(`CMIS_ADDR_STATUS, rd, resp);
				check(rd[10:8], {f == 1 || f == 2, f == 2, 1'b0});
			end
		end
		set_ctrl(7, 0, 0, 0);
		axi_read(`CMIS_ADDR_CTRL, rd, resp);
		check(rd, 32'h0000_0005);
		$display("Test strobe routing done");
		@(posedge mclk);
		ext_low <= 1'b1;
		for (k = 0; k < 5; k++) begin
			set_ctrl(fn_tab[k], 0, 0, 0);
			watch(WIN, fn_tab[k] == 0 || fn_tab[k] == 3, ce, lo);
			check(near(ce, exp_tab[k]), 1);
			check(inhibit, 0);
			check(lo > 0, 1);
			if (k == 0) begin
				axi_read(`CMIS_ADDR_READING, rd, resp);
				check(near(rd, 2 * 8 * DW / 4), 1);
			end
		end
		$display("Test input routing done");
		@(posedge mclk);
		ext_low <= 1'b0;
		set_ctrl(4, 0, 0, 0);
		watch(400, 1, ce, lo);
		check(near(ce, 100), 1);
		check(inhibit, 0);
		for (k = 0; k < 2; k++) begin
			@(posedge mclk);
			ext_low <= (k == 0);
			set_ctrl(4, 0, k, 0);
			watch(40, 0, ce, lo);
			check(ce, 0);
			check({inhibit, direct_gate, counter_in}, 3'b110);
		end
		$display("Test totalize inhibit done");
		axi_read(`CMIS_ADDR_LIVE, rd, resp);
		check(rd != 0, 1);
		set_ctrl(4, 0, 1, 1);
		axi_read(`CMIS_ADDR_LIVE, rd, resp);
		check(rd, 32'h0000_0000);
		axi_read(`CMIS_ADDR_READING, rd, resp);
		check(rd, 32'h0000_0000);
		axi_read(`CMIS_ADDR_CTRL, rd, resp);
		check(rd, 32'h0000_0104);
		$display("Test reading clear done");
		complete_run();
	end
endmodule : testbench
